// ---- src/fsg_params.svh ----
// Constants for the flash security write/erase gate.
// Assumes an 8-bit register port and a 16-bit flash byte address.
`ifndef FSG_PARAMS_SVH
`define FSG_PARAMS_SVH
// ==========================================================
// Register offsets
`define FSG_PSC_ADDR 8'h8f
`define FSG_KEY_ADDR 8'hb7
`define FSG_RSRC_ADDR 8'hef
`define FSG_SUP_ADDR 8'hfe
// ==========================================================
// Field positions and reset values
`define FSG_WE_BIT 0
`define FSG_EE_BIT 1
`define FSG_MON_EN_BIT 0
`define FSG_MON_RST_BIT 1
`define FSG_FERR_BIT 6
`define FSG_CTL_RST 2'h0
`define FSG_SUP_ON 2'h3
`define FSG_KEY_CODE1 8'ha5
`define FSG_KEY_CODE2 8'hf1
// ==========================================================
// Flash map
`define FSG_PAGE_LSB 9
`define FSG_PAGE_MSB 15
`define FSG_LOCK_ADDR 16'h7dff
`define FSG_LOCK_PAGE 7'h3e
`define FSG_RSVD_BASE 16'h7e00
`define FSG_ERASED 8'hff
`define FSG_PAGE_OFS 9'h000
// ==========================================================
// Timing: 250 MHz clock, waits are least times so they round up
`define FSG_CLK_MHZ 64'd250
`define FSG_WRITE_NS 64'd57000
`define FSG_ERASE_NS 64'd24000000
`define FSG_WRITE_CYC ((`FSG_WRITE_NS * `FSG_CLK_MHZ + 64'd999) / 64'd1000)
`define FSG_ERASE_CYC ((`FSG_ERASE_NS * `FSG_CLK_MHZ + 64'd999) / 64'd1000)
`endif

// ---- src/fsg_pkg.sv ----
// Types shared by the flash security gate.
// Assumes fsg_params.svh supplies all numeric constants.
package fsg_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        S_INIT, S_INIT_RD, S_INIT_CAP, S_IDLE, S_RD, S_RD_CAP, S_WAIT, S_FAULT
    } fsg_state_e;
    // Flash operation, also the debug command code
    typedef enum logic [1:0] {OP_RD, OP_WR, OP_PERASE, OP_MASS} fsg_op_e;
    // Unlock key progress, read back as its code
    typedef enum logic [1:0] {KEY_LOCKED, KEY_FIRST, KEY_OPEN, KEY_DEAD} fsg_key_e;
endpackage

// ---- src/fsg_gate.sv ----
// Flash access gate: checks firmware requests against the page lock, key and supply
// monitor and debug requests against the page lock, drives a flash macro, raises error reset.
// Assumes a flash macro with one-cycle read latency and a system reset
// tree that pulls sys_rst_i while dev_rst_o is high.
`timescale 1ns/1ns
`include "fsg_params.svh"
module fsg_gate
    import fsg_pkg::*;
#(
    parameter int WRITE_CYCLES = int'(`FSG_WRITE_CYC),
    parameter int ERASE_CYCLES = int'(`FSG_ERASE_CYC)
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic por_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic fw_rd_i,
    input wire logic fw_xwr_i,
    input wire logic [15:0] fw_addr_i,
    input wire logic [7:0] fw_wdata_i,
    input wire logic [15:0] fw_pc_i,
    output logic [7:0] fw_rdata_o,
    output logic fw_rvalid_o,
    input wire logic dbg_req_i,
    input wire logic [1:0] dbg_cmd_i,
    input wire logic [15:0] dbg_addr_i,
    input wire logic [7:0] dbg_wdata_i,
    output logic [7:0] dbg_rdata_o,
    output logic dbg_done_o,
    output logic dbg_ok_o,
    output logic xram_wr_o,
    output logic [15:0] xram_addr_o,
    output logic [7:0] xram_wdata_o,
    output logic [15:0] fl_addr_o,
    output logic [7:0] fl_wdata_o,
    output logic fl_rd_o,
    output logic fl_wr_o,
    output logic fl_erase_o,
    output logic fl_mass_o,
    input wire logic [7:0] fl_rdata_i,
    output logic busy_o,
    output logic irq_hold_o,
    output logic dev_rst_o
);
    // ==========================================================
    // State
    fsg_state_e state_q;
    fsg_op_e op_q;
    fsg_key_e key_q;
    logic src_dbg_q, err_pend_q, ferr_q;
    logic [15:0] addr_q;
    logic [7:0] data_q, lock_q;
    logic [1:0] psc_q, sup_q;
    logic [22:0] wait_q;
    // ==========================================================
    // Request decode and security decision
    logic req_dbg, req_fw, idle, modify, any_locked, pc_locked, tgt_locked;
    logic rsvd, lock_pg, sec_ok, sup_bad, key_bad, go, fault_idle, fault_chk;
    logic lock_viol, mass_go, key_used, key_burn;
    logic [7:0] lock_n;
    logic [15:0] ra;
    fsg_op_e op_w;
    assign idle = (state_q == S_IDLE);
    assign req_dbg = dbg_req_i;
    assign req_fw = !dbg_req_i && (fw_rd_i || (fw_xwr_i && psc_q[`FSG_WE_BIT]));
    assign ra = req_dbg ? dbg_addr_i : fw_addr_i;
    assign lock_n = ~lock_q;
    assign any_locked = (lock_q != `FSG_ERASED);
    assign lock_pg = (ra[`FSG_PAGE_MSB:`FSG_PAGE_LSB] == `FSG_LOCK_PAGE);
    assign rsvd = (ra >= `FSG_RSVD_BASE);
    // Lock-byte page joins the locked set as soon as any page is locked
    assign tgt_locked = ({1'b0, ra[`FSG_PAGE_MSB:`FSG_PAGE_LSB]} < lock_n)
        || (lock_pg && any_locked);
    assign pc_locked = ({1'b0, fw_pc_i[`FSG_PAGE_MSB:`FSG_PAGE_LSB]} < lock_n)
        || ((fw_pc_i[`FSG_PAGE_MSB:`FSG_PAGE_LSB] == `FSG_LOCK_PAGE) && any_locked);
    // Operation: firmware read wins over a store in the same cycle
    always_comb begin
        if (req_dbg) begin
            op_w = fsg_op_e'(dbg_cmd_i);
        end else if (fw_rd_i) begin
            op_w = OP_RD;
        end else if (psc_q[`FSG_EE_BIT]) begin
            op_w = OP_PERASE;
        end else begin
            op_w = OP_WR;
        end
    end
    // Security table by source, target and lock state
    always_comb begin
        if (op_w == OP_MASS) begin
            sec_ok = req_dbg;
        end else if (rsvd) begin
            sec_ok = 1'b0;
        end else if (op_w == OP_PERASE && lock_pg) begin
            sec_ok = req_dbg && !any_locked;
        end else if (tgt_locked) begin
            sec_ok = !req_dbg && pc_locked;
        end else begin
            sec_ok = 1'b1;
        end
    end
    assign modify = (op_w != OP_RD);
    assign sup_bad = !req_dbg && modify && (sup_q != `FSG_SUP_ON);
    assign key_bad = !req_dbg && modify && (key_q != KEY_OPEN);
    assign fault_idle = idle && req_fw && (sup_bad || !sec_ok);
    assign key_burn = idle && req_fw && !sup_bad && sec_ok && key_bad;
    assign go = idle && (req_dbg || req_fw) && sec_ok && !sup_bad && !key_bad;
    assign key_used = go && req_fw && modify;
    assign mass_go = go && (op_w == OP_MASS);
    // A programmed lock byte may never be rewritten
    assign lock_viol = (addr_q == `FSG_LOCK_ADDR) && (fl_rdata_i != `FSG_ERASED);
    assign fault_chk = (state_q == S_RD_CAP) && (op_q == OP_WR) && !src_dbg_q && lock_viol;
    // ==========================================================
    // Sequencer and flash strobes
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_INIT;
            op_q <= OP_RD;
            src_dbg_q <= 1'b0;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            lock_q <= 8'hff;
            wait_q <= 23'h000000;
            fl_addr_o <= 16'h0000;
            fl_wdata_o <= 8'h00;
            fl_rd_o <= 1'b0;
            fl_wr_o <= 1'b0;
            fl_erase_o <= 1'b0;
            fl_mass_o <= 1'b0;
            fw_rdata_o <= 8'h00;
            fw_rvalid_o <= 1'b0;
            dbg_rdata_o <= 8'h00;
            dbg_done_o <= 1'b0;
            dbg_ok_o <= 1'b0;
            busy_o <= 1'b1;
            irq_hold_o <= 1'b0;
            dev_rst_o <= 1'b0;
        end else begin
            fl_rd_o <= 1'b0;
            fl_wr_o <= 1'b0;
            fl_erase_o <= 1'b0;
            fl_mass_o <= 1'b0;
            fw_rvalid_o <= 1'b0;
            dbg_done_o <= 1'b0;
            unique case (state_q)
                // Lock state is sampled once per reset, so a new lock byte waits
                S_INIT: begin
                    fl_addr_o <= `FSG_LOCK_ADDR;
                    fl_rd_o <= 1'b1;
                    state_q <= S_INIT_RD;
                end
                S_INIT_RD: state_q <= S_INIT_CAP;
                S_INIT_CAP: begin
                    lock_q <= fl_rdata_i;
                    busy_o <= 1'b0;
                    state_q <= S_IDLE;
                end
                S_IDLE: begin
                    op_q <= op_w;
                    src_dbg_q <= req_dbg;
                    addr_q <= ra;
                    data_q <= req_dbg ? dbg_wdata_i : fw_wdata_i;
                    if (fault_idle) begin
                        dev_rst_o <= 1'b1;
                        busy_o <= 1'b1;
                        state_q <= S_FAULT;
                    end else if (idle && req_dbg && !sec_ok) begin
                        dbg_done_o <= 1'b1;
                        dbg_ok_o <= 1'b0;
                    end else if (go && (op_w == OP_RD || op_w == OP_WR)) begin
                        // Writes read the old byte first to merge it
                        fl_addr_o <= ra;
                        fl_rd_o <= 1'b1;
                        busy_o <= 1'b1;
                        state_q <= S_RD;
                    end else if (go) begin
                        fl_addr_o <= {ra[`FSG_PAGE_MSB:`FSG_PAGE_LSB], `FSG_PAGE_OFS};
                        fl_erase_o <= (op_w == OP_PERASE);
                        fl_mass_o <= (op_w == OP_MASS);
                        if (op_w == OP_MASS) begin
                            lock_q <= `FSG_ERASED;
                        end
                        wait_q <= ERASE_CYCLES[22:0];
                        irq_hold_o <= 1'b1;
                        busy_o <= 1'b1;
                        state_q <= S_WAIT;
                    end
                end
                S_RD: state_q <= S_RD_CAP;
                S_RD_CAP: begin
                    if (op_q == OP_RD) begin
                        fw_rdata_o <= src_dbg_q ? fw_rdata_o : fl_rdata_i;
                        fw_rvalid_o <= !src_dbg_q;
                        dbg_rdata_o <= src_dbg_q ? fl_rdata_i : dbg_rdata_o;
                        dbg_done_o <= src_dbg_q;
                        dbg_ok_o <= 1'b1;
                        busy_o <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (fault_chk) begin
                        dev_rst_o <= 1'b1;
                        state_q <= S_FAULT;
                    end else if (src_dbg_q && lock_viol) begin
                        dbg_done_o <= 1'b1;
                        dbg_ok_o <= 1'b0;
                        busy_o <= 1'b0;
                        state_q <= S_IDLE;
                    end else begin
                        fl_wdata_o <= data_q & fl_rdata_i;
                        fl_wr_o <= 1'b1;
                        wait_q <= WRITE_CYCLES[22:0];
                        irq_hold_o <= 1'b1;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (wait_q <= 23'h000001) begin
                        irq_hold_o <= 1'b0;
                        busy_o <= 1'b0;
                        dbg_done_o <= src_dbg_q;
                        dbg_ok_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        wait_q <= wait_q - 23'h000001;
                    end
                end
                // Held until the reset tree answers; nothing else runs
                S_FAULT: dev_rst_o <= 1'b1;
            endcase
        end
    end
    // ==========================================================
    // Unlock key: a bad code or an early attempt disables until reset
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            key_q <= KEY_LOCKED;
        end else if (key_burn) begin
            key_q <= KEY_DEAD;
        end else if (key_used) begin
            key_q <= KEY_LOCKED;
        end else if (reg_wr_i && reg_addr_i == `FSG_KEY_ADDR && key_q != KEY_DEAD) begin
            if (key_q == KEY_LOCKED && reg_wdata_i == `FSG_KEY_CODE1) begin
                key_q <= KEY_FIRST;
            end else if (key_q == KEY_FIRST && reg_wdata_i == `FSG_KEY_CODE2) begin
                key_q <= KEY_OPEN;
            end else begin
                key_q <= KEY_DEAD;
            end
        end
    end
    // ==========================================================
    // Control registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            psc_q <= `FSG_CTL_RST;
            sup_q <= `FSG_CTL_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `FSG_PSC_ADDR) begin
                psc_q <= reg_wdata_i[1:0];
            end
            if (reg_addr_i == `FSG_SUP_ADDR) begin
                sup_q <= reg_wdata_i[1:0];
            end
        end
    end
    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                `FSG_PSC_ADDR: reg_rdata_o <= {6'h00, psc_q};
                `FSG_KEY_ADDR: reg_rdata_o <= {6'h00, 2'(key_q)};
                `FSG_SUP_ADDR: reg_rdata_o <= {6'h00, sup_q};
                `FSG_RSRC_ADDR: reg_rdata_o <= 8'(ferr_q) << `FSG_FERR_BIT;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
    // ==========================================================
    // Error flag outlives its reset; copied once at lock capture, as S_INIT repeats in reset
    always_ff @(posedge ref_clk_i or posedge por_rst_i) begin
        if (por_rst_i) begin
            err_pend_q <= 1'b0;
            ferr_q <= 1'b0;
        end else if (fault_idle || fault_chk) begin
            err_pend_q <= 1'b1;
        end else if (state_q == S_INIT_CAP) begin
            ferr_q <= err_pend_q;
            err_pend_q <= 1'b0;
        end
    end
    // External stores go to data RAM while write enable is clear
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xram_wr_o <= 1'b0;
            xram_addr_o <= 16'h0000;
            xram_wdata_o <= 8'h00;
        end else begin
            xram_wr_o <= fw_xwr_i && !psc_q[`FSG_WE_BIT];
            xram_addr_o <= fw_addr_i;
            xram_wdata_o <= fw_wdata_i;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_fw_store;
        idle && !dbg_req_i && !fw_rd_i && fw_xwr_i && psc_q[`FSG_WE_BIT];
    endsequence
    sequence s_hold8; irq_hold_o [*8]; endsequence
    a_key_open_order: assert property ((key_q == KEY_OPEN && $past(key_q) != KEY_OPEN)
        |-> $past(reg_wr_i && reg_wdata_i == `FSG_KEY_CODE2 && key_q == KEY_FIRST))
        else $error("key opened without second code");
    a_store_merge: assert property (fl_wr_o
        |-> (fl_wdata_o & ~$past(fl_rdata_i)) == 8'h00) else $error("flash write sets a bit");
    a_dbg_no_reset: assert property (req_dbg && idle
        |=> !dev_rst_o) else $error("debug request caused reset");
    a_fault_held: assert property ($rose(dev_rst_o)
        |-> dev_rst_o [*8]) else $error("error reset not held");
    a_supply_gate: assert property (s_fw_store ##0 (sup_q != `FSG_SUP_ON)
        |=> dev_rst_o && state_q == S_FAULT) else $error("store without supply monitor not reset");
    a_ram_route: assert property (fw_xwr_i && !psc_q[`FSG_WE_BIT]
        |=> xram_wr_o ##1 !fl_wr_o) else $error("store not routed to data RAM");
    a_page_erase: assert property (s_fw_store ##0 psc_q[`FSG_EE_BIT] && go
        |=> fl_erase_o && fl_addr_o[8:0] == `FSG_PAGE_OFS) else $error("page erase not issued");
    a_rsvd_refuse: assert property (idle && req_dbg && dbg_addr_i >= `FSG_RSVD_BASE
        && dbg_cmd_i != 2'h3 |=> dbg_done_o && !dbg_ok_o)
        else $error("reserved debug access not refused");
    a_irq_held: assert property ($rose(irq_hold_o) |-> s_hold8)
        else $error("interrupt hold too short");
    a_lock_stable: assert property (!(state_q == S_INIT_CAP || mass_go)
        |=> $stable(lock_q)) else $error("lock state changed without reset");
endmodule

// ---- dv/fsg_flash_model.sv ----
// Behavioural flash macro that sits behind the access gate.
// Assumes one-cycle read data and 32 KB of byte-wide array.
`timescale 1ns/1ns
module fsg_flash_model #(
    parameter logic [7:0] LOCK_INIT = 8'hfd
) (
    input wire logic ref_clk_i,
    input wire logic [15:0] fl_addr_i,
    input wire logic [7:0] fl_wdata_i,
    input wire logic fl_rd_i,
    input wire logic fl_wr_i,
    input wire logic fl_erase_i,
    input wire logic fl_mass_i,
    output logic [7:0] fl_rdata_o
);
    logic [7:0] mem [0:32767];
    logic [7:0] q = 8'h00;
    logic vld = 1'b0;
    // ==========================================================
    // Array preset
    // Address pattern everywhere, lock byte last: two pages locked
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
        mem[15'h7dff] = LOCK_INIT;
    end
    // ==========================================================
    // Array operations
    // Outside its read slot the data line shows junk, so a stale byte never passes
    assign fl_rdata_o = vld ? q : ~q;
    always @(posedge ref_clk_i) begin
        vld <= fl_rd_i;
        if (fl_rd_i) q <= mem[fl_addr_i[14:0]];
        if (fl_wr_i) mem[fl_addr_i[14:0]] <= mem[fl_addr_i[14:0]] & fl_wdata_i;
        if (fl_erase_i) for (int i = 0; i < 512; i++) mem[{fl_addr_i[14:9], 9'(i)}] <= 8'hff;
        if (fl_mass_i) for (int i = 0; i < 32768; i++) mem[i] <= 8'hff;
    end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the flash access gate with a flash macro model.
// Assumes the gate's header constants and short write and erase waits.
`timescale 1ns/1ns
`include "fsg_params.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic [7:0] ra = 8'h00, rwd = 8'h00, fwd = 8'h00, dwd = 8'h00;
    logic rwr = 1'b0, rrd = 1'b0, frd = 1'b0, fxw = 1'b0, dreq = 1'b0;
    logic [1:0] dcmd = 2'h0;
    logic [15:0] fa = 16'h0000, fpc = 16'h0000, da = 16'h0000;
    logic [7:0] rdo, fro, dro, xwd, flwd, fld, v;
    logic frv, ddone, dok, xwr, flrd, flwr, fler, flms, busy, irqh, drst, hold, xs;
    logic [15:0] xa, fla, a;
    logic [15:0] rnd = 16'h0059;
    int err_count = 0, num_checks = 0, cyc = 0;
    // ==========================================================
    // Design, flash model and clock
    fsg_gate #(.WRITE_CYCLES(10), .ERASE_CYCLES(20)) uut (
        .ref_clk_i(clk), .sys_rst_i(rst), .por_rst_i(por), .reg_addr_i(ra),
        .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdo),
        .fw_rd_i(frd), .fw_xwr_i(fxw), .fw_addr_i(fa), .fw_wdata_i(fwd), .fw_pc_i(fpc),
        .fw_rdata_o(fro), .fw_rvalid_o(frv), .dbg_req_i(dreq), .dbg_cmd_i(dcmd),
        .dbg_addr_i(da), .dbg_wdata_i(dwd), .dbg_rdata_o(dro), .dbg_done_o(ddone),
        .dbg_ok_o(dok), .xram_wr_o(xwr), .xram_addr_o(xa), .xram_wdata_o(xwd),
        .fl_addr_o(fla), .fl_wdata_o(flwd), .fl_rd_o(flrd), .fl_wr_o(flwr),
        .fl_erase_o(fler), .fl_mass_o(flms), .fl_rdata_i(fld), .busy_o(busy),
        .irq_hold_o(irqh), .dev_rst_o(drst));
    fsg_flash_model fl (.ref_clk_i(clk), .fl_addr_i(fla), .fl_wdata_i(flwd), .fl_rd_i(flrd),
        .fl_wr_i(flwr), .fl_erase_i(fler), .fl_mass_i(flms), .fl_rdata_o(fld));
    initial forever #2 clk = ~clk;
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Preset content of an untouched flash byte
    function automatic logic [7:0] pat(input logic [15:0] x);
        return x[7:0] ^ {1'b0, x[14:8]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        int n = 0;
        while (n < 100 && busy !== 1'b0) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic rst_dev(input int n);
        @(posedge clk);
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        wait_idle();
    endtask
    task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        ra <= ad;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge clk);
        ra <= ad;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 d = rdo;
    endtask
    // Supply bits, both key codes, then the control register
    task automatic arm(input logic [7:0] sup, input logic [7:0] ctl);
        reg_wr(`FSG_SUP_ADDR, sup);
        reg_wr(`FSG_KEY_ADDR, `FSG_KEY_CODE1);
        reg_wr(`FSG_KEY_ADDR, `FSG_KEY_CODE2);
        reg_wr(`FSG_PSC_ADDR, ctl);
    endtask
    // Debug request; a refusal must never reset the device
    task automatic dbg(input logic [1:0] c, input logic [15:0] ad, input logic [7:0] d,
                       input logic okx);
        int n = 0;
        wait_idle();
        @(posedge clk);
        dcmd <= c;
        da <= ad;
        dwd <= d;
        dreq <= 1'b1;
        @(posedge clk);
        dreq <= 1'b0;
        // A refusal answers on the request edge itself, so look just after it
        #1;
        while (n < 60 && ddone !== 1'b1) begin
            @(posedge clk);
            #1 n++;
        end
        chk(ddone, 1'b1);
        chk(dok, okx);
        chk(drst, 1'b0);
    endtask
    // Firmware code read or store; stops early if the gate requests a reset
    task automatic fw(input logic st, input logic [15:0] ad, input logic [7:0] d,
                      input logic [15:0] pc);
        int n = 0;
        wait_idle();
        @(posedge clk);
        fa <= ad;
        fwd <= d;
        fpc <= pc;
        frd <= !st;
        fxw <= st;
        @(posedge clk);
        frd <= 1'b0;
        fxw <= 1'b0;
        #1 xs = xwr;
        hold = irqh;
        while (n < 60 && drst !== 1'b1 && (st ? busy !== 1'b0 : frv !== 1'b1)) begin
            @(posedge clk);
            #1 hold |= irqh;
            n++;
        end
    endtask
    task automatic expect_rst();
        chk(drst, 1'b1);
        rst_dev(2);
        reg_rd(`FSG_RSRC_ADDR, v);
        chk(v[`FSG_FERR_BIT], 1'b1);
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_dev(10);
        reg_rd(`FSG_PSC_ADDR, v);
        chk(v, 8'h00);
        reg_wr(`FSG_PSC_ADDR, 8'hff);
        reg_rd(`FSG_PSC_ADDR, v);
        chk(v, 8'h03);
        reg_rd(8'h00, v);
        chk(v, 8'h00);
        reg_wr(`FSG_PSC_ADDR, 8'h00);
        $display("test 1 done");
        dbg(2'h0, 16'h0100, 8'h00, 1'b0);
        dbg(2'h0, 16'h7c00, 8'h00, 1'b0);
        dbg(2'h0, `FSG_LOCK_ADDR, 8'h00, 1'b0);
        dbg(2'h1, `FSG_LOCK_ADDR, 8'h00, 1'b0);
        dbg(2'h2, 16'h7e00, 8'h00, 1'b0);
        dbg(2'h2, 16'h7c00, 8'h00, 1'b0);
        // Random open pages from the debug port and unlocked-page code
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            a = 16'h0400 + (rnd & 16'h3bff);
            dbg(2'h0, a, 8'h00, 1'b1);
            chk(dro, pat(a));
            fw(1'b0, a, 8'h00, 16'h0800);
            chk(fro, pat(a));
        end
        fw(1'b0, 16'h0123, 8'h00, 16'h0010);
        chk(fro, pat(16'h0123));
        fw(1'b0, `FSG_LOCK_ADDR, 8'h00, 16'h0010);
        chk(fro, 8'hfd);
        $display("test 2 done");
        fw(1'b0, 16'h0123, 8'h00, 16'h0400);
        expect_rst();
        arm(8'h00, 8'h01);
        fw(1'b1, 16'h0655, 8'h0f, 16'h0800);
        expect_rst();
        $display("test 3 done");
        arm(8'h03, 8'h01);
        fw(1'b1, 16'h0655, 8'h0f, 16'h0800);
        chk(hold, 1'b1);
        dbg(2'h0, 16'h0655, 8'h00, 1'b1);
        chk(dro, 8'h03);
        reg_rd(`FSG_KEY_ADDR, v);
        chk(v[1:0], 2'h0);
        reg_wr(`FSG_PSC_ADDR, 8'h00);
        fw(1'b1, 16'h0655, 8'hff, 16'h0800);
        chk(xs, 1'b1);
        chk(xa[7:0], 8'h55);
        chk(xwd, 8'hff);
        arm(8'h03, 8'h03);
        fw(1'b1, 16'h0655, 8'h00, 16'h0800);
        dbg(2'h0, 16'h0600, 8'h00, 1'b1);
        chk(dro, 8'hff);
        reg_wr(`FSG_PSC_ADDR, 8'h01);
        fw(1'b1, 16'h0700, 8'h00, 16'h0800);
        reg_rd(`FSG_KEY_ADDR, v);
        chk(v[1:0], 2'h3);
        dbg(2'h0, 16'h0700, 8'h00, 1'b1);
        // The page was erased above; a store past the dead key would leave zeros
        chk(dro, `FSG_ERASED);
        $display("test 4 done");
        rst_dev(2);
        reg_rd(`FSG_RSRC_ADDR, v);
        chk(v, 8'h00);
        arm(8'h03, 8'h03);
        fw(1'b1, 16'h7c10, 8'h00, 16'h0010);
        expect_rst();
        dbg(2'h3, 16'h0000, 8'h00, 1'b1);
        dbg(2'h0, `FSG_LOCK_ADDR, 8'h00, 1'b1);
        chk(dro, 8'hff);
        dbg(2'h2, 16'h7c00, 8'h00, 1'b1);
        arm(8'h03, 8'h01);
        fw(1'b1, `FSG_LOCK_ADDR, 8'hfe, 16'h0800);
        dbg(2'h0, 16'h0123, 8'h00, 1'b1);
        rst_dev(2);
        dbg(2'h0, 16'h0123, 8'h00, 1'b0);
        dbg(2'h0, 16'h0200, 8'h00, 1'b1);
        dbg(2'h1, `FSG_LOCK_ADDR, 8'h00, 1'b0);
        $display("test 5 done");
        stop_test();
    end
endmodule
